// File: design/mcm_pkg.sv
package mcm_pkg;

	// Link word and microcode word geometry.
	localparam int W      = 16;
	localparam int SEG_N  = 14;
	localparam int MW     = W * SEG_N;
	localparam int SEG_W  = 4;
	localparam int AW     = 6;
	localparam int DEPTH  = 64;
	localparam int SW_W   = 8;

	// Function codes as numbers; bit 2 is the most significant.
	localparam logic [2:0] FN_NULL   = 3'h0;
	localparam logic [2:0] FN_RDMEM  = 3'h1;
	localparam logic [2:0] FN_WRMEM  = 3'h2;
	localparam logic [2:0] FN_SPARE  = 3'h3;
	localparam logic [2:0] FN_DATA   = 3'h4;
	localparam logic [2:0] FN_RDSTAT = 3'h5;
	localparam logic [2:0] FN_WRSW   = 3'h6;
	localparam logic [2:0] FN_EOP    = 3'h7;

	// Control output channel bit positions.
	localparam int CTL_INIT = 0;
	localparam int CTL_MSB  = 1;
	localparam int CTL_MID  = 2;
	localparam int CTL_LSB  = 3;

	// Dummy address words that follow each initiated function except EOP and 011.
	localparam logic [1:0] DUMMY_N = 2'h2;

	// Write switch bit positions and groups.
	localparam int SW_GO    = 0;
	localparam int SW_KILL  = 1;
	localparam int SW_SENSE = 2;
	localparam int SW_ZERO  = 3;
	localparam int SW_AUX   = 4;
	localparam logic [SW_W-1:0] SW_LATCH_M = 8'hE6;
	localparam logic [SW_W-1:0] SW_SHOT_M  = 8'h19;

	// Status word 1: run bit at 0, latched switches above it.
	localparam int ST1_RUN = 0;

	// Register map of the controller, byte addresses.
	localparam logic [11:0] REG_CMD  = 12'h000;
	localparam logic [11:0] REG_DOUT = 12'h004;
	localparam logic [11:0] REG_DIN  = 12'h008;
	localparam logic [11:0] REG_STAT = 12'h00C;
	localparam logic [11:0] REG_ISEL = 12'h010;
	localparam logic [11:0] REG_CSW  = 12'h014;

	// Command register fields.
	localparam int CMD_ISSUE = 3;

	// Selection words: bit A and 9 of one, bits 8 and 9 of the other.
	localparam int ISEL_ON  = 10;
	localparam int ISEL_OFF = 9;
	localparam int CSW_ON   = 8;
	localparam int CSW_OFF  = 9;

	// Controller status register bits.
	localparam int HST_BUSY    = 0;
	localparam int HST_DVALID  = 1;
	localparam int HST_ALIGNED = 2;
	localparam int HST_LINK    = 3;

endpackage

// File: design/mcm_link_if.sv
`timescale 1ns/1ps
interface mcm_link_if;
	logic [3:0]  ctl;
	logic        out_stb;
	logic [15:0] out_data;
	logic        in_req;
	logic        in_stb;
	logic [15:0] in_data;

	modport ctl_end (
		output ctl,
		output out_stb,
		output out_data,
		output in_req,
		input  in_stb,
		input  in_data
	);

	modport mem_end (
		input  ctl,
		input  out_stb,
		input  out_data,
		input  in_req,
		output in_stb,
		output in_data
	);
endinterface

// File: design/mcm_fanio.sv
`timescale 1ns/1ps
module mcm_fanio
	import mcm_pkg::*;
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Control
	input  wire logic             clr,
	input  wire logic             step,
	// Data
	input  wire logic [W-1:0]     din,
	input  wire logic [MW-1:0]    src,
	output logic      [SEG_W-1:0] seg,
	output logic                  last,
	output logic      [MW-1:0]    full,
	output logic      [W-1:0]     slice
);
	logic [SEG_W-1:0] seg_q;
	logic [SEG_W-1:0] seg_d;
	logic [MW-1:0]    asm_q;

	assign seg   = seg_q;
	assign last  = (seg_q == SEG_W'(SEG_N - 1));
	assign seg_d = last ? '0 : seg_q + SEG_W'(1);
	assign slice = src[seg_q * W +: W];

	// The current segment is spliced in so a full word exists on the
	// same edge as its last half word.
	genvar gi;
	generate
		for (gi = 0; gi < SEG_N; gi++) begin : g_seg
			assign full[gi*W +: W] = (seg_q == SEG_W'(gi)) ?
				din : asm_q[gi*W +: W];
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seg_q <= '0;
			asm_q <= '0;
		end else if (clr) begin
			seg_q <= '0;
		end else if (step) begin
			seg_q <= seg_d;
			asm_q <= full;
		end
	end
endmodule

// File: design/mcm_mem_end.sv
`timescale 1ns/1ps
// What this block does
// - No parity checked, reported, or sent.
// - Code on bits 1-3, bit 3 LSB.
// - Null code follows every issued function.
// - Read code streams words from current address.
// - Write code stores words at current address.
// - EOP and 011 cancel functions, clear segments.
// - EOP keeps the address counter.
// - Data code accompanies write and switch words.
// - Read status code reports microcode status.
// - Switch code captures control word into register.
// - Bits 0,3,4 fire only when newly set.
// - Bits 0 and 3 act one cycle late.
// - 1 kills, 3 zeroes address, 0 starts, 2 senses.
// - Bits 1,2,5,6,7 latch; repeat both halves.
// - Status word 1, then word 2 repeated.
// - Status reads change nothing.
// - Status carries run bit.
// - Operator selects control interface first.
// - Operator routes control channel here.
// - Code, initiate, two dummy words, drop.
// - Dummy address words discarded, address kept.
// - Write blocks are multiples of fourteen words.
// - 224-bit words from fourteen 16-bit words.
module mcm_mem_end
	import mcm_pkg::*;
(
	// Clock and reset
	input  wire logic            pclk,
	input  wire logic            presetn,
	// Link to the maintenance side
	mcm_link_if.mem_end          lk,
	// Microcode execution controls
	output logic                 run,
	output logic                 sense,
	output logic                 aux_pulse,
	output logic [SW_W-1:0]      sw_level,
	output logic [AW-1:0]        mc_addr
);
	typedef enum logic [4:0] {
		OP_IDLE = 5'b00001,
		OP_RD   = 5'b00010,
		OP_WR   = 5'b00100,
		OP_ST   = 5'b01000,
		OP_SW   = 5'b10000
	} mcm_op_t;

	mcm_op_t          op_q;
	logic             init_q;
	logic [1:0]       dummy_q;
	logic             st2_q;
	logic [SW_W-1:0]  sw_q;
	logic [SW_W-1:0]  prev_q;
	logic             go_dly_q;
	logic             zero_dly_q;
	logic             aux_q;
	logic             run_q;
	logic [AW-1:0]    addr_q;
	logic             in_stb_q;
	logic [W-1:0]     in_data_q;
	logic [MW-1:0]    mem [DEPTH];

	wire logic [2:0]      code_w;
	wire logic            init_rise;
	wire logic            eop_w;
	wire logic            in_dummy;
	wire logic            data_w;
	wire logic            wr_step;
	wire logic            rd_step;
	wire logic            sw_step;
	wire logic [SW_W-1:0] sw_word;
	wire logic [SW_W-1:0] sw_new;
	wire logic [W-1:0]    stat1_w;
	wire logic [W-1:0]    stat2_w;
	wire logic [SEG_W-1:0] seg_w;
	wire logic            last_w;
	wire logic [MW-1:0]   full_w;
	wire logic [W-1:0]    slice_w;
	wire logic [MW-1:0]   cur_w;

	// Bit 3 carries the least significant code bit.
	assign code_w = {lk.ctl[CTL_MSB], lk.ctl[CTL_MID],
		lk.ctl[CTL_LSB]};
	assign init_rise = lk.ctl[CTL_INIT] & ~init_q;
	// The spare code behaves like end of operation.
	assign eop_w = init_rise &
		((code_w == FN_EOP) | (code_w == FN_SPARE));
	assign in_dummy = (dummy_q != 2'h0);
	assign data_w = (code_w == FN_DATA);
	assign wr_step = lk.out_stb & ~in_dummy & data_w &
		(op_q == OP_WR);
	assign sw_step = lk.out_stb & ~in_dummy & data_w &
		(op_q == OP_SW);
	assign rd_step = lk.in_req & ~in_dummy & (op_q == OP_RD);

	assign sw_word = lk.out_data[SW_W-1:0];
	// Edge against the previous half word, so a held bit fires once.
	assign sw_new = sw_word & ~prev_q & SW_SHOT_M;

	// No parity bit exists anywhere on the returned words.
	assign stat1_w = {8'h00, sw_q[SW_W-1:1], run_q};
	assign stat2_w = {6'h00, seg_w, addr_q};

	assign cur_w = mem[addr_q];

	mcm_fanio u_fanio (
		.pclk    (pclk),
		.presetn (presetn),
		.clr     (eop_w),
		.step    (wr_step | rd_step),
		.din     (lk.out_data),
		.src     (cur_w),
		.seg     (seg_w),
		.last    (last_w),
		.full    (full_w),
		.slice   (slice_w)
	);

	assign run       = run_q;
	assign sense     = sw_q[SW_SENSE];
	assign aux_pulse = aux_q;
	assign sw_level  = sw_q;
	assign mc_addr   = addr_q;
	assign lk.in_stb  = in_stb_q;
	assign lk.in_data = in_data_q;

	// Function decode and dummy address handling.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			init_q  <= 1'b0;
			op_q    <= OP_IDLE;
			dummy_q <= 2'h0;
			st2_q   <= 1'b0;
		end else begin
			init_q <= lk.ctl[CTL_INIT];
			if (eop_w) begin
				op_q    <= OP_IDLE;
				dummy_q <= 2'h0;
			end else if (init_rise && code_w != FN_NULL &&
				code_w != FN_DATA) begin
				dummy_q <= DUMMY_N;
				st2_q   <= 1'b0;
				unique case (code_w)
					FN_RDMEM:  op_q <= OP_RD;
					FN_WRMEM:  op_q <= OP_WR;
					FN_RDSTAT: op_q <= OP_ST;
					default:   op_q <= OP_SW;
				endcase
			end else if (lk.out_stb && in_dummy) begin
				dummy_q <= dummy_q - 2'h1;
			end else if (lk.in_req && op_q == OP_ST) begin
				st2_q <= 1'b1;
			end
		end
	end

	// Answers to input requests, one cycle after the request.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_stb_q  <= 1'b0;
			in_data_q <= '0;
		end else begin
			in_stb_q <= lk.in_req;
			if (lk.in_req) begin
				if (op_q == OP_ST)
					in_data_q <= st2_q ? stat2_w : stat1_w;
				else if (rd_step)
					in_data_q <= slice_w;
				else
					in_data_q <= '0;
			end
		end
	end

	// Switch register and the two delayed actions.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sw_q       <= '0;
			prev_q     <= '0;
			go_dly_q   <= 1'b0;
			zero_dly_q <= 1'b0;
			aux_q      <= 1'b0;
		end else begin
			go_dly_q   <= sw_step & sw_new[SW_GO];
			zero_dly_q <= sw_step & sw_new[SW_ZERO];
			aux_q      <= sw_step & sw_new[SW_AUX];
			if (init_rise && code_w == FN_WRSW)
				prev_q <= '0;
			else if (sw_step)
				prev_q <= sw_word;
			if (sw_step)
				sw_q <= (sw_word & SW_LATCH_M) |
					(sw_q & ~SW_LATCH_M);
		end
	end

	// Run flag: kill acts at once, start only after the delay so that
	// a kill in the same word cannot cancel it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			run_q <= 1'b0;
		else if (go_dly_q)
			run_q <= 1'b1;
		else if (sw_step && sw_word[SW_KILL])
			run_q <= 1'b0;
	end

	// Address counter; end of operation leaves it where it is.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			addr_q <= '0;
		else if (zero_dly_q)
			addr_q <= '0;
		else if ((wr_step | rd_step) && last_w)
			addr_q <= addr_q + AW'(1);
	end

	// Memory array has no reset; contents are loaded over the link.
	always_ff @(posedge pclk) begin
		if (wr_step && last_w)
			mem[addr_q] <= full_w;
	end
endmodule

// File: design/mcm_ctl_end.sv
// The APB slave port and the register addresses were decided locally.
`timescale 1ns/1ps
module mcm_ctl_end
	import mcm_pkg::*;
(
	// Clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Link to the microcode side
	mcm_link_if.ctl_end      lk,
	// Selection words
	output logic      [15:0] isel_word,
	output logic      [15:0] csw_word
);
	typedef enum logic [5:0] {
		H_IDLE  = 6'b000001,
		H_SETUP = 6'b000010,
		H_INIT  = 6'b000100,
		H_DUMMY = 6'b001000,
		H_DROP  = 6'b010000,
		H_NULL  = 6'b100000
	} mcm_hst_t;

	mcm_hst_t    st_q;
	logic [2:0]  code_q;
	logic        init_q;
	logic        dcnt_q;
	logic        out_stb_q;
	logic [15:0] out_data_q;
	logic        in_req_q;
	logic [15:0] din_q;
	logic        dval_q;
	logic [3:0]  wcnt_q;
	logic [15:0] isel_q;
	logic [15:0] csw_q;
	logic [31:0] prdata_q;
	logic        pready_q;
	logic        pslverr_q;

	wire logic        acc;
	wire logic        fire;
	wire logic        busy;
	wire logic        link_on;
	wire logic        hit_cmd;
	wire logic        hit_dout;
	wire logic        hit_din;
	wire logic        hit_stat;
	wire logic        hit_isel;
	wire logic        hit_csw;
	wire logic        mapped;
	wire logic        link_wr;
	wire logic        stall;
	wire logic        bad;
	wire logic        ok_fire;
	wire logic        short_fn;
	wire logic [31:0] rd_mux;

	assign busy    = (st_q != H_IDLE);
	// The link is only driven once both selection words point here.
	assign link_on = isel_q[ISEL_ON] & ~isel_q[ISEL_OFF] &
		csw_q[CSW_ON] & ~csw_q[CSW_OFF];
	assign hit_cmd  = (paddr == REG_CMD);
	assign hit_dout = (paddr == REG_DOUT);
	assign hit_din  = (paddr == REG_DIN);
	assign hit_stat = (paddr == REG_STAT);
	assign hit_isel = (paddr == REG_ISEL);
	assign hit_csw  = (paddr == REG_CSW);
	assign mapped = hit_cmd | hit_dout | hit_din | hit_stat |
		hit_isel | hit_csw;
	assign link_wr = pwrite & (hit_cmd | hit_dout | hit_din);
	assign acc   = psel & penable & ~pready_q;
	// Link writes wait for the function sequence to finish.
	assign stall = link_wr & busy;
	assign bad   = ~mapped | (link_wr & ~link_on);
	assign fire  = psel & penable & pready_q;
	assign ok_fire = fire & ~pslverr_q;
	assign short_fn = (code_q == FN_EOP) | (code_q == FN_SPARE);
	assign rd_mux = hit_din  ? {16'h0000, din_q} :
		hit_stat ? {28'h0000000, link_on, (wcnt_q == 4'h0),
			dval_q, busy} :
		hit_cmd  ? {29'h00000000, code_q} :
		hit_isel ? {16'h0000, isel_q} :
		hit_csw  ? {16'h0000, csw_q} : 32'h00000000;

	assign prdata    = prdata_q;
	assign pready    = pready_q;
	assign pslverr   = pslverr_q;
	assign isel_word = isel_q;
	assign csw_word  = csw_q;
	assign lk.ctl      = {code_q[0], code_q[1], code_q[2], init_q};
	assign lk.out_stb  = out_stb_q;
	assign lk.out_data = out_data_q;
	assign lk.in_req   = in_req_q;

	// APB answer: registered, one wait state at least.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= '0;
		end else begin
			pready_q  <= acc & ~stall;
			pslverr_q <= acc & ~stall & bad;
			if (acc && !stall)
				prdata_q <= pwrite ? 32'h00000000 : rd_mux;
		end
	end

	// Function sequencer.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_q   <= H_IDLE;
			code_q <= FN_NULL;
			init_q <= 1'b0;
			dcnt_q <= 1'b0;
		end else begin
			unique case (st_q)
				H_IDLE: if (ok_fire && pwrite && hit_cmd) begin
					code_q <= pwdata[2:0];
					if (pwdata[CMD_ISSUE])
						st_q <= H_SETUP;
				end
				H_SETUP: begin
					init_q <= 1'b1;
					st_q   <= H_INIT;
				end
				H_INIT: begin
					dcnt_q <= 1'b0;
					st_q   <= short_fn ? H_DROP : H_DUMMY;
				end
				H_DUMMY: begin
					dcnt_q <= 1'b1;
					if (dcnt_q)
						st_q <= H_DROP;
				end
				H_DROP: begin
					init_q <= 1'b0;
					st_q   <= H_NULL;
				end
				H_NULL: begin
					code_q <= FN_NULL;
					st_q   <= H_IDLE;
				end
			endcase
		end
	end

	// Outgoing words: dummy address words, then software data words.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_stb_q  <= 1'b0;
			out_data_q <= '0;
			in_req_q   <= 1'b0;
			wcnt_q     <= '0;
		end else begin
			out_stb_q <= 1'b0;
			in_req_q  <= ok_fire & pwrite & hit_din;
			if (st_q == H_DUMMY) begin
				out_stb_q  <= 1'b1;
				out_data_q <= '0;
			end else if (ok_fire && pwrite && hit_dout) begin
				out_stb_q  <= 1'b1;
				out_data_q <= pwdata[15:0];
				// Tracks block length modulo fourteen.
				wcnt_q <= (wcnt_q == 4'(SEG_N - 1)) ? 4'h0 :
					wcnt_q + 4'h1;
			end else if (ok_fire && pwrite && hit_cmd) begin
				wcnt_q <= '0;
			end
		end
	end

	// Returned word holder; a new word wins over a read that clears it.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			din_q  <= '0;
			dval_q <= 1'b0;
			isel_q <= '0;
			csw_q  <= '0;
		end else begin
			if (lk.in_stb) begin
				din_q  <= lk.in_data;
				dval_q <= 1'b1;
			end else if (ok_fire && !pwrite && hit_din) begin
				dval_q <= 1'b0;
			end
			if (ok_fire && pwrite && hit_isel)
				isel_q <= pwdata[15:0];
			if (ok_fire && pwrite && hit_csw)
				csw_q <= pwdata[15:0];
		end
	end
endmodule

// File: dv/mcm_link_checker.sv
`timescale 1ns/1ps
module mcm_link_checker
	import mcm_pkg::*;
(
	// Clock and reset
	input wire logic        pclk,
	input wire logic        presetn,
	// Link signals
	input wire logic [3:0]  ctl,
	input wire logic        out_stb,
	input wire logic [15:0] out_data,
	input wire logic        in_req,
	input wire logic        in_stb,
	input wire logic [15:0] in_data
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	// Code bits travel with the most significant on ctl[1].
	wire [2:0] fn_code = {ctl[1], ctl[2], ctl[3]};
	// Codes 011 and 111 both end the operation and send no dummy words.
	wire       ends_op = ctl[2] & ctl[3];

	sequence s_dummy_pair;
		(out_stb && out_data == 16'h0000 && ctl[0])[*2];
	endsequence

	sequence s_drop_null;
		(!ctl[0] && !out_stb) ##1 (ctl[3:1] == 3'h0);
	endsequence

	// Initiate is seen high two edges before the first dummy word, and
	// drops on the edge right after the second dummy word.
	a_dummy_then_null: assert property (
		$rose(ctl[0]) && !ends_op |=> ##1 s_dummy_pair ##1 s_drop_null)
		else $error("dummy address words or null code missing");
	a_end_no_dummy: assert property (
		$rose(ctl[0]) && ends_op |=> ##1 s_drop_null)
		else $error("end code not dropped at once");
	a_null_after_fall: assert property (
		$fell(ctl[0]) |=> ctl[3:1] == 3'h0)
		else $error("null code not sent after a function");
	a_code_steady: assert property (
		ctl[0] |-> $stable(ctl[3:1]))
		else $error("function code moved while initiate high");
	a_init_real_code: assert property (
		$rose(ctl[0]) |-> fn_code != FN_NULL && fn_code != FN_DATA)
		else $error("initiate raised with null or data code");
	a_reply_next: assert property (
		in_req |=> in_stb)
		else $error("input word not returned one cycle after request");
	a_reply_caused: assert property (
		in_stb |-> $past(in_req))
		else $error("input strobe without a request");
	a_data_held: assert property (
		!in_stb |-> $stable(in_data))
		else $error("input data changed without a strobe");
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
module testbench
	import mcm_pkg::*;
;
	logic        pclk = 1'b0;
	logic        presetn, psel, penable, pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic        pready, pslverr, er;
	logic [15:0] isel_word, csw_word;
	logic        run, sense, aux_pulse;
	logic [7:0]  sw_level;
	logic [5:0]  mc_addr;
	int          errors = 0;
	int          compares = 0;
	int          aux_n = 0;

	mcm_link_if lk();

	mcm_ctl_end mcm_ctl_end_inst (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .lk(lk), .isel_word(isel_word),
		.csw_word(csw_word));

	mcm_mem_end mcm_mem_end_inst (.pclk(pclk), .presetn(presetn),
		.lk(lk), .run(run), .sense(sense), .aux_pulse(aux_pulse),
		.sw_level(sw_level), .mc_addr(mc_addr));

	mcm_link_checker mcm_link_checker_inst (.pclk(pclk),
		.presetn(presetn), .ctl(lk.ctl), .out_stb(lk.out_stb),
		.out_data(lk.out_data), .in_req(lk.in_req), .in_stb(lk.in_stb),
		.in_data(lk.in_data));

	always #12.5 pclk = ~pclk;

	// The auxiliary one-shot is too short to catch from the bus side.
	always @(posedge pclk) begin
		if (aux_pulse === 1'b1)
			aux_n++;
	end

	task automatic chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		compares++;
		if (got !== ex) begin
			errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, ex, got);
		end
	endtask

	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int n;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 40);
		if (pready !== 1'b1)
			errors++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		// Outputs are looked at only after this edge's updates settle.
		@(negedge pclk);
	endtask

	// Polling busy keeps the bench free of sequencer cycle counts.
	task automatic fn(input logic [2:0] c);
		int n;
		apb(1'b1, REG_CMD, {28'h0, 1'b1, c});
		n = 0;
		do begin
			apb(1'b0, REG_STAT, 32'h0);
			n++;
		end while (rd[HST_BUSY] !== 1'b0 && n < 20);
		if (rd[HST_BUSY] !== 1'b0)
			errors++;
	endtask

	task automatic sw(input logic [15:0] w);
		apb(1'b1, REG_DOUT, {16'h0, w});
		repeat (4) @(negedge pclk);
	endtask

	task automatic final_report;
		$display("compares %0d errors %0d", compares, errors);
		if (errors == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge pclk);
		errors++;
		final_report();
	end

	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b1, REG_CMD, {28'h0, 1'b1, FN_EOP});
		chk("unselected error", 32'h1, {31'h0, er});
		apb(1'b0, 12'h020, 32'h0);
		chk("unmapped error", 32'h1, {31'h0, er});
		chk("unmapped data", 32'h0, rd);
		apb(1'b1, REG_ISEL, 32'h0000_0400);
		apb(1'b1, REG_CSW, 32'h0000_0100);
		chk("select accepted", 32'h0, {31'h0, er});
		chk("isel word", 32'h400, {16'h0, isel_word});
		chk("csw word", 32'h100, {16'h0, csw_word});
		apb(1'b0, REG_STAT, 32'h0);
		chk("link selected", 32'h1, {31'h0, rd[HST_LINK]});
		$display("test select done");
		fn(FN_EOP);
		fn(FN_WRMEM);
		apb(1'b1, REG_CMD, {29'h0, FN_DATA});
		for (int i = 0; i < 28; i++) begin
			apb(1'b1, REG_DOUT, {16'h0, 16'hA000 + i[15:0]});
			if (i == 12) begin
				apb(1'b0, REG_STAT, 32'h0);
				chk("aligned", 32'h0, {31'h0, rd[HST_ALIGNED]});
			end
		end
		apb(1'b0, REG_STAT, 32'h0);
		chk("aligned", 32'h1, {31'h0, rd[HST_ALIGNED]});
		apb(1'b1, REG_CMD, 32'h0);
		chk("addr after write", 32'h2, {26'h0, mc_addr});
		fn(FN_EOP);
		chk("addr after end", 32'h2, {26'h0, mc_addr});
		$display("test write done");
		fn(FN_WRSW);
		apb(1'b1, REG_CMD, {29'h0, FN_DATA});
		sw(16'h0009);
		chk("run go", 32'h1, {31'h0, run});
		chk("addr zero", 32'h0, {26'h0, mc_addr});
		sw(16'h0000);
		sw(16'h0026);
		chk("run kill", 32'h0, {31'h0, run});
		chk("sense", 32'h1, {31'h0, sense});
		chk("latched", 32'h26, {24'h0, sw_level});
		sw(16'h0001);
		chk("run again", 32'h1, {31'h0, run});
		sw(16'h0003);
		chk("go held", 32'h0, {31'h0, run});
		chk("latched", 32'h02, {24'h0, sw_level});
		sw(16'h0010);
		sw(16'h0010);
		sw(16'h0000);
		sw(16'h00F8);
		chk("aux count", 32'h2, aux_n);
		chk("addr zero", 32'h0, {26'h0, mc_addr});
		chk("latched", 32'hE0, {24'h0, sw_level});
		apb(1'b1, REG_CMD, 32'h0);
		fn(FN_EOP);
		$display("test switch done");
		fn(FN_RDMEM);
		for (int i = 0; i < 28; i++) begin
			apb(1'b1, REG_DIN, 32'h0);
			apb(1'b0, REG_DIN, 32'h0);
			chk("read word", {16'h0, 16'hA000 + i[15:0]}, rd);
		end
		chk("addr after read", 32'h2, {26'h0, mc_addr});
		fn(FN_EOP);
		$display("test read done");
		fn(FN_RDSTAT);
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, REG_DIN, 32'h0);
			apb(1'b0, REG_DIN, 32'h0);
			chk("status", (i == 0) ? 32'h00E0 : 32'h0002, rd);
		end
		chk("addr kept", 32'h2, {26'h0, mc_addr});
		chk("latched kept", 32'hE0, {24'h0, sw_level});
		fn(FN_EOP);
		$display("test status done");
		final_report();
	end
endmodule
